//--- rtl/load_link_if.sv
// Frame hand-over from the serial capture to the modulator core
`include "pwm_regs.svh"

interface load_link_if;
   logic load_stb;
   serial_loaded_modulator_pkg::load_len_type load_len;
   logic [`FRAME_WIDTH-1:0] load_data;

   modport source (output load_stb, output load_len, output load_data);
   modport sink (input load_stb, input load_len, input load_data);
endinterface : load_link_if

//--- rtl/pwm_regs.svh
// Field positions, frame lengths and reset values of the serial modulator
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

// --------------------------------------------------------------------------
// Control byte fields
// --------------------------------------------------------------------------
`define CTRL_RATE_HALVE_BIT 0
`define CTRL_POWER_DOWN_BIT 1
`define CTRL_WIDTH 2

// --------------------------------------------------------------------------
// Serial frame layout, last byte shifted sits lowest
// --------------------------------------------------------------------------
`define FRAME_WIDTH 24
`define BYTE_WIDTH 8
`define HIGH_TIME_LSB 0
`define PERIOD_LSB 8
`define CTRL_LSB 16

// --------------------------------------------------------------------------
// Bit counts of legal loads and the saturating overflow mark
// --------------------------------------------------------------------------
`define BITS_WIDTH 5
`define BITS_ONE_BYTE 5'h08
`define BITS_TWO_BYTE 5'h10
`define BITS_FULL 5'h18
`define BITS_OVER 5'h19

// --------------------------------------------------------------------------
// Reset values
// --------------------------------------------------------------------------
`define CTRL_RESET 2'h0
`define BYTE_RESET 8'h00
`define BITS_RESET 5'h00
`define SYNC_RESET 3'h2 // Idle pins: clock low, select high, data low
`define SRC_SYNC_RESET 2'h0

`endif

//--- rtl/serial_capture.sv
// Serial port capture: pin synchronisers, shift register and frame latch
`include "pwm_regs.svh"

module serial_capture (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic sck_i,
   input wire logic sel_n_i,
   input wire logic data_i,
   load_link_if.source link
);

   // -----------------------------------------------------------------------
   // Pin synchronisers: bit 2 clock, bit 1 select, bit 0 data
   // -----------------------------------------------------------------------
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [2:0] s3_r;
   logic [2:0] filt_r;
   logic [2:0] filt_nxt;
   wire [2:0] pins = {sck_i, sel_n_i, data_i};

   // A change counts only once the second and third stages agree
   assign filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r | s3_r));

   // Every stage starts at the idle pin levels, else the first cycles
   // after reset would see a select edge that never happened
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s1_r <= `SYNC_RESET;
         s2_r <= `SYNC_RESET;
         s3_r <= `SYNC_RESET;
         filt_r <= `SYNC_RESET;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= filt_nxt;
      end
   end

   // -----------------------------------------------------------------------
   // Edge decode
   // -----------------------------------------------------------------------
   wire selected = ~filt_r[1];
   wire sck_rise = filt_nxt[2] & ~filt_r[2];
   wire sel_fall = ~filt_nxt[1] & filt_r[1];
   wire sel_rise = filt_nxt[1] & ~filt_r[1];
   wire shift_en = selected & sck_rise; // R16

   // -----------------------------------------------------------------------
   // Shift register and bit counter
   // -----------------------------------------------------------------------
   logic [`FRAME_WIDTH-1:0] shift_r;
   logic [`BITS_WIDTH-1:0] bits_r;
   logic [`BITS_WIDTH-1:0] bits_inc;

   // Saturate so that long frames stay recognisably illegal
   assign bits_inc = (bits_r == `BITS_OVER) ? bits_r : bits_r + 5'h01;

   // MSB first: older bits move up, newest enters at bit 0
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         shift_r <= '0;
         bits_r <= `BITS_RESET;
      end else if (sel_fall) begin
         bits_r <= `BITS_RESET; // R19
      end else if (shift_en) begin
         shift_r <= {shift_r[`FRAME_WIDTH-2:0], filt_r[0]}; // R16
         bits_r <= bits_inc;
      end
   end

   // -----------------------------------------------------------------------
   // Frame latch on deselect
   // -----------------------------------------------------------------------
   serial_loaded_modulator_pkg::load_len_type len_class;
   assign len_class = (bits_r == `BITS_ONE_BYTE) ?
                         serial_loaded_modulator_pkg::LEN_ONE :
                      (bits_r == `BITS_TWO_BYTE) ?
                         serial_loaded_modulator_pkg::LEN_TWO :
                      (bits_r == `BITS_FULL) ?
                         serial_loaded_modulator_pkg::LEN_FULL :
                         serial_loaded_modulator_pkg::LEN_BAD; // R21

   logic stb_r;
   serial_loaded_modulator_pkg::load_len_type len_r;
   logic [`FRAME_WIDTH-1:0] data_r;

   // One-cycle strobe with the frame held until the next deselect
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         stb_r <= 1'b0;
         len_r <= serial_loaded_modulator_pkg::LEN_BAD;
         data_r <= '0;
      end else begin
         stb_r <= sel_rise; // R19
         if (sel_rise) begin
            len_r <= len_class;
            data_r <= shift_r;
         end
      end
   end

   assign link.load_stb = stb_r;
   assign link.load_len = len_r;
   assign link.load_data = data_r;

endmodule : serial_capture

//--- rtl/serial_loaded_modulator.sv
// Serially loaded clock-dividing pulse width modulator, top level
//
// Notes on behaviour
// R1: A new load takes effect only when the present output period ends.
// R2: After full setup, a one-byte load rewrites only the high time.
// R3: A two-byte load carries period then high time; both are latched.
// R4: Divider or power-down changes need a full three-byte load.
// R5: Control byte bits 7 to 2 are ignored.
// R6: Power-down bit set stops counting and the threshold sense.
// R7: Only a full load with power-down clear wakes the device.
// R8: Rate-halve bit set counts at half the input clock rate.
// R9: Period is (period + 1) times (rate-halve + 1) input clocks.
// R10: High for (high time + 1) times (rate-halve + 1) clocks, then low.
// R11: Deselect after a load starts a high phase when not running.
// R12: Later output changes follow falling input clock edges.
// R13: Waveform repeats until reprogrammed or threshold sense trips.
// R14: Master sends MSB first, framed by select low then high.
// R15: Master sends whole bytes: control, period, high time, or a tail.
// R16: Data is shifted in on each rising serial clock edge.
// R17: Output stays low until a first full 24-bit load is latched.
// R18: Threshold sense forces low until it clears and a load follows.
// R19: Select falling selects; select rising latches the shifted bytes.
// R20: Serial pins are synchronised before any value takes effect.
// R21: Frames of other than 8, 16 or 24 bits change nothing.
`include "pwm_regs.svh"

module serial_loaded_modulator (
   input wire logic CORE_CLK_I,
   input wire logic SRST_I,
   input wire logic SCK_I,
   input wire logic SEL_N_I,
   input wire logic DATA_I,
   input wire logic PWM_CLK_I,
   input wire logic THRESHOLD_SENSE_I,
   output logic PWM_O,
   output logic POWER_DOWN_O
);

   // -----------------------------------------------------------------------
   // Serial capture
   // -----------------------------------------------------------------------
   load_link_if link ();

   // All serial pins cross into the core clock here
   serial_capture capture (
      .clk_i (CORE_CLK_I),
      .srst_i (SRST_I),
      .sck_i (SCK_I),
      .sel_n_i (SEL_N_I),
      .data_i (DATA_I),
      .link (link.source)
   ); // R20

   // -----------------------------------------------------------------------
   // Source clock and threshold synchronisers
   // -----------------------------------------------------------------------
   logic [1:0] p1_r;
   logic [1:0] p2_r;
   logic [1:0] p3_r;
   logic [1:0] pf_r;
   logic [1:0] pf_nxt;
   wire [1:0] pins = {PWM_CLK_I, THRESHOLD_SENSE_I};

   // Filtered level moves only when stages two and three agree
   assign pf_nxt = (p2_r & p3_r) | (pf_r & (p2_r | p3_r));

   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         p1_r <= `SRC_SYNC_RESET;
         p2_r <= `SRC_SYNC_RESET;
         p3_r <= `SRC_SYNC_RESET;
         pf_r <= `SRC_SYNC_RESET;
      end else begin
         p1_r <= pins;
         p2_r <= p1_r;
         p3_r <= p2_r;
         pf_r <= pf_nxt;
      end
   end

   wire src_fall = pf_r[1] & ~pf_nxt[1]; // R12
   wire thresh = pf_r[0];

   // -----------------------------------------------------------------------
   // Latched data registers and frame decode
   // -----------------------------------------------------------------------
   logic [`CTRL_WIDTH-1:0] pwm_control_r;
   logic [`BYTE_WIDTH-1:0] period_count_r;
   logic [`BYTE_WIDTH-1:0] high_time_count_r;
   logic [`CTRL_WIDTH-1:0] pwm_control_nxt;
   logic [`BYTE_WIDTH-1:0] period_count_nxt;
   logic [`BYTE_WIDTH-1:0] high_time_count_nxt;
   serial_loaded_modulator_pkg::run_state_type state_r;
   serial_loaded_modulator_pkg::run_state_type state_nxt;

   wire [`FRAME_WIDTH-1:0] fd = link.load_data;
   wire is_full = link.load_len == serial_loaded_modulator_pkg::LEN_FULL;
   wire is_two = link.load_len == serial_loaded_modulator_pkg::LEN_TWO;
   wire is_one = link.load_len == serial_loaded_modulator_pkg::LEN_ONE;
   // Short loads count only once set up and awake
   wire short_ok = (state_r != serial_loaded_modulator_pkg::ST_OFF) &&
                   (state_r != serial_loaded_modulator_pkg::ST_SLEEP);
   wire accept = link.load_stb &&
                 (is_full || (short_ok && (is_one || is_two))); // R21 R7

   // Control keeps only its two low bits; upper six are dropped
   wire [`CTRL_WIDTH-1:0] frame_ctrl =
      fd[`CTRL_LSB +: `CTRL_WIDTH]; // R5
   wire [`BYTE_WIDTH-1:0] frame_period = fd[`PERIOD_LSB +: `BYTE_WIDTH];
   wire [`BYTE_WIDTH-1:0] frame_high = fd[`HIGH_TIME_LSB +: `BYTE_WIDTH];

   // Length selects which registers a load touches
   assign pwm_control_nxt = (accept && is_full) ?
                            frame_ctrl : pwm_control_r; // R4
   assign period_count_nxt = (accept && (is_full || is_two)) ?
                             frame_period : period_count_r; // R3
   assign high_time_count_nxt = accept ?
                                frame_high : high_time_count_r; // R2 R3

   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         pwm_control_r <= `CTRL_RESET;
         period_count_r <= `BYTE_RESET;
         high_time_count_r <= `BYTE_RESET;
      end else begin
         pwm_control_r <= pwm_control_nxt;
         period_count_r <= period_count_nxt;
         high_time_count_r <= high_time_count_nxt;
      end
   end

   // -----------------------------------------------------------------------
   // Operating state
   // -----------------------------------------------------------------------
   wire new_pd = pwm_control_nxt[`CTRL_POWER_DOWN_BIT];
   wire running = state_r == serial_loaded_modulator_pkg::ST_RUN;
   logic start;

   // Power-down and threshold act at once; settings wait for period end
   always_comb begin
      state_nxt = state_r;
      start = 1'b0;
      unique case (state_r)
         serial_loaded_modulator_pkg::ST_OFF,
         serial_loaded_modulator_pkg::ST_SLEEP,
         serial_loaded_modulator_pkg::ST_FORCED: begin
            if (accept && is_full && new_pd) begin
               state_nxt = serial_loaded_modulator_pkg::ST_SLEEP; // R6
            end else if (accept && !thresh) begin
               state_nxt = serial_loaded_modulator_pkg::ST_RUN; // R11 R17 R18
               start = 1'b1;
            end else if (accept) begin
               state_nxt = serial_loaded_modulator_pkg::ST_FORCED; // R18
            end
         end
         serial_loaded_modulator_pkg::ST_RUN: begin
            if (accept && is_full && new_pd) begin
               state_nxt = serial_loaded_modulator_pkg::ST_SLEEP; // R6
            end else if (thresh) begin
               state_nxt = serial_loaded_modulator_pkg::ST_FORCED; // R18 R13
            end
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         state_r <= serial_loaded_modulator_pkg::ST_OFF; // R17
      end else begin
         state_r <= state_nxt;
      end
   end

   // -----------------------------------------------------------------------
   // Active settings and waveform counter
   // -----------------------------------------------------------------------
   logic act_halve_r;
   logic [`BYTE_WIDTH-1:0] act_period_r;
   logic [`BYTE_WIDTH-1:0] act_high_r;
   logic pend_r;
   logic pre_r;
   logic [`BYTE_WIDTH-1:0] cnt_r;
   logic out_r;

   // Halved rate lets every second falling edge through
   wire tick = running && src_fall &&
               (!act_halve_r || pre_r); // R8
   wire at_end = tick && (cnt_r == act_period_r); // R9
   wire at_high_end = tick && (cnt_r == act_high_r); // R10
   // Loads landing on the end cycle are folded in, not lost
   wire take = start || (at_end && (pend_r || accept)); // R1

   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         act_halve_r <= 1'b0;
         act_period_r <= `BYTE_RESET;
         act_high_r <= `BYTE_RESET;
      end else if (take) begin
         act_halve_r <= pwm_control_nxt[`CTRL_RATE_HALVE_BIT]; // R8
         act_period_r <= period_count_nxt;
         act_high_r <= high_time_count_nxt;
      end
   end

   // Pending update waits for the end of the present period
   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I || take) begin
         pend_r <= 1'b0;
      end else if (accept && running) begin
         pend_r <= 1'b1; // R1
      end
   end

   // Period start clears the prescaler and counter
   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I || start || at_end) begin
         pre_r <= 1'b0;
         cnt_r <= `BYTE_RESET;
      end else if (running && src_fall) begin
         pre_r <= ~pre_r;
         if (tick) begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end

   // Output rises at start and period end, falls after the high time
   always_ff @(posedge CORE_CLK_I) begin
      if (SRST_I || (state_nxt != serial_loaded_modulator_pkg::ST_RUN)) begin
         out_r <= 1'b0; // R17 R18 R6
      end else if (start || at_end) begin
         out_r <= 1'b1; // R11 R12 R13
      end else if (at_high_end) begin
         out_r <= 1'b0; // R10 R12
      end
   end

   assign PWM_O = out_r;
   assign POWER_DOWN_O = state_r == serial_loaded_modulator_pkg::ST_SLEEP;

endmodule : serial_loaded_modulator

//--- rtl/serial_loaded_modulator_pkg.sv
// Types shared by the serial capture and the modulator core
package serial_loaded_modulator_pkg;

   // Length class of a completed select frame
   typedef enum logic [1:0] {
      LEN_BAD,
      LEN_ONE,
      LEN_TWO,
      LEN_FULL
   } load_len_type;

   // Operating state of the modulator
   typedef enum logic [1:0] {
      ST_OFF,
      ST_SLEEP,
      ST_FORCED,
      ST_RUN
   } run_state_type;

endpackage : serial_loaded_modulator_pkg

//--- verification/serial_loaded_modulator_monitor.sv
// Port checker of the serial loaded modulator, bound to its top level
module serial_loaded_modulator_monitor (
   input wire logic CORE_CLK_I,
   input wire logic SRST_I,
   input wire logic SCK_I,
   input wire logic SEL_N_I,
   input wire logic DATA_I,
   input wire logic PWM_CLK_I,
   input wire logic THRESHOLD_SENSE_I,
   input wire logic PWM_O,
   input wire logic POWER_DOWN_O
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sck_q;
   logic sel_q;
   logic src_q;
   logic loaded_r;
   logic [4:0] bits_r;
   logic [4:0] len_r;
   logic [3:0] since_sel;
   logic [3:0] since_fall;
   wire sel_rise = SEL_N_I && !sel_q;
   wire src_fall = !PWM_CLK_I && src_q;

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (SRST_I);

   // Raw pin edges; the counters saturate so idle time never wraps
   always_ff @(posedge CORE_CLK_I) begin
      sck_q <= SCK_I;
      sel_q <= SEL_N_I;
      src_q <= PWM_CLK_I;
      bits_r <= SEL_N_I ? 5'h00 : bits_r + 5'(SCK_I && !sck_q);
      len_r <= SRST_I ? 5'h00 : (sel_rise ? bits_r : len_r);
      loaded_r <= !SRST_I && (loaded_r || (sel_rise && bits_r == 5'h18));
      since_sel <= (SRST_I || sel_rise) ? 4'h0 :
         since_sel + 4'(since_sel != 4'hF);
      since_fall <= (SRST_I || src_fall) ? 4'h0 :
         since_fall + 4'(since_fall != 4'hF);
   end

   a_sleep_output_low: assert property (POWER_DOWN_O |-> !PWM_O)
      else $error("output high while asleep");
   a_threshold_forces_low: assert property (
      THRESHOLD_SENSE_I [*6] |-> !PWM_O)
      else $error("output not forced low");
   a_no_output_unloaded: assert property (!loaded_r |-> !PWM_O)
      else $error("output high before full load");
   a_rise_has_cause: assert property ($rose(PWM_O) |->
      since_fall inside {[4'h1:4'h7]} || since_sel inside {[4'h2:4'h8]})
      else $error("output rose without cause");
   a_fall_has_cause: assert property ($fell(PWM_O) |->
      since_fall inside {[4'h1:4'h7]} || since_sel <= 4'h8 ||
      $past(THRESHOLD_SENSE_I, 4))
      else $error("output fell without cause");
   a_wake_needs_full: assert property (
      $fell(POWER_DOWN_O) |-> len_r == 5'h18)
      else $error("woken by short load");
   a_sleep_needs_full: assert property (
      $rose(POWER_DOWN_O) |-> len_r == 5'h18)
      else $error("sleep entered by short load");
   a_sleep_follows_load: assert property (
      $changed(POWER_DOWN_O) |-> since_sel inside {[4'h2:4'h8]})
      else $error("power down changed away from a load");
endmodule : serial_loaded_modulator_monitor

bind serial_loaded_modulator serial_loaded_modulator_monitor
   i_serial_loaded_modulator_monitor (
   .CORE_CLK_I(CORE_CLK_I),
   .SRST_I(SRST_I),
   .SCK_I(SCK_I),
   .SEL_N_I(SEL_N_I),
   .DATA_I(DATA_I),
   .PWM_CLK_I(PWM_CLK_I),
   .THRESHOLD_SENSE_I(THRESHOLD_SENSE_I),
   .PWM_O(PWM_O),
   .POWER_DOWN_O(POWER_DOWN_O)
);

//--- verification/serial_loaded_modulator_tb.sv
// Testbench of the serial loaded modulator: loads and waveform checks
module serial_loaded_modulator_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic pwm_clk = 1'b0;
   logic threshold = 1'b0;
   logic sck;
   logic sel_n;
   logic data;
   logic pwm;
   logic power_down;
   int n_fail = 0;
   int checks_done = 0;
   int div_cnt = 0;

`define CHECK(got, exp, msg) \
   begin \
      checks_done++; \
      if ((got) !== (exp)) begin \
         n_fail++; \
         $display("[FAIL] %0t %s", $time, msg); \
      end \
   end

   // Core clock, and a source clock of ten core cycles to divide
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      div_cnt <= (div_cnt == 4) ? 0 : div_cnt + 1;
      if (div_cnt == 4) begin
         pwm_clk <= ~pwm_clk;
      end
   end

   serial_loaded_modulator i_serial_loaded_modulator (
      .CORE_CLK_I(core_clk),
      .SRST_I(srst),
      .SCK_I(sck),
      .SEL_N_I(sel_n),
      .DATA_I(data),
      .PWM_CLK_I(pwm_clk),
      .THRESHOLD_SENSE_I(threshold),
      .PWM_O(pwm),
      .POWER_DOWN_O(power_down)
   );

   spi_master_model i_spi_master_model (
      .clk_i(core_clk),
      .sck_o(sck),
      .sel_n_o(sel_n),
      .data_o(data)
   );

   task automatic test_done;
      if (n_fail == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   // Load, then let the latch and sync stages settle before sampling
   task automatic load(input int n, input logic [23:0] w);
      i_spi_master_model.send(n, w);
      repeat (3) @(negedge core_clk);
   endtask : load

   // Bounded wait for an output level; a hang ends the run
   task automatic wait_lvl(input logic v);
      int n;
      n = 0;
      while (pwm !== v) begin
         @(negedge core_clk);
         n++;
         if (n > 4000) begin
            n_fail++;
            $display("[FAIL] %0t output stuck", $time);
            test_done();
         end
      end
   endtask : wait_lvl

   // Skips the period in flight and the one after it, so reloads settle, then times one period
   task automatic measure(input int hi, input int per);
      int h;
      int p;
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      h = 0;
      while (pwm === 1'b1 && h < 4000) begin
         @(negedge core_clk);
         h++;
      end
      p = h;
      while (pwm === 1'b0 && p < 8000) begin
         @(negedge core_clk);
         p++;
      end
      `CHECK(h, hi * 10, "high time")
      `CHECK(p, per * 10, "period")
   endtask : measure

   initial begin
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      @(negedge core_clk);
      `CHECK(pwm, 1'b0, "output after reset")
      `CHECK(power_down, 1'b0, "awake after reset")
      load(16, 24'h000401);
      repeat (100) @(negedge core_clk);
      `CHECK(pwm, 1'b0, "output before full load")
      load(24, 24'hFC0401);
      `CHECK(pwm, 1'b1, "rise at deselect")
      measure(2, 5);
      load(24, 24'h010F00);
      measure(2, 32);
      wait_lvl(1'b1);
      load(8, 24'h000002);
      `CHECK(pwm, 1'b0, "old period kept")
      measure(6, 32);
      load(16, 24'h000501);
      measure(4, 12);
      load(12, 24'h000F0F);
      measure(4, 12);
      @(posedge core_clk) threshold <= 1'b1;
      repeat (10) @(negedge core_clk);
      `CHECK(pwm, 1'b0, "forced low")
      @(posedge core_clk) threshold <= 1'b0;
      repeat (200) @(negedge core_clk);
      `CHECK(pwm, 1'b0, "still forced")
      load(8, 24'h000000);
      measure(2, 12);
      load(24, 24'h020501);
      `CHECK(power_down, 1'b1, "asleep")
      `CHECK(pwm, 1'b0, "output while asleep")
      load(16, 24'h000501);
      `CHECK(power_down, 1'b1, "short load kept sleep")
      load(24, 24'h000200);
      `CHECK(power_down, 1'b0, "full load wakes")
      measure(1, 3);
      test_done();
   end
endmodule : serial_loaded_modulator_tb

//--- verification/spi_master_model.sv
// Serial master model that frames register loads onto the select port
module spi_master_model (
   input wire logic clk_i,
   output logic sck_o,
   output logic sel_n_o,
   output logic data_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle port: clock low, device not selected
   initial begin
      sck_o = 1'b0;
      sel_n_o = 1'b1;
      data_o = 1'b0;
   end

   // Bytes go MSB first; every level held 5 cycles for the pin filters
   task automatic send(input int nbits, input logic [23:0] word);
      @(posedge clk_i);
      sel_n_o <= 1'b0;
      repeat (5) @(posedge clk_i);
      for (int i = nbits - 1; i >= 0; i--) begin
         data_o <= word[i];
         repeat (5) @(posedge clk_i);
         sck_o <= 1'b1;
         repeat (5) @(posedge clk_i);
         sck_o <= 1'b0;
      end
      repeat (5) @(posedge clk_i);
      sel_n_o <= 1'b1;
      data_o <= ~data_o; // Released line shows no stale bit
      repeat (5) @(posedge clk_i);
   endtask : send
endmodule : spi_master_model
